/* File: logic/msc_stats.sv */
// MAC statistics counter bank with a classic Wishbone slave
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module msc_stats #(
  parameter int unsigned CNT_W = msc_pkg::MSC_CNT_W
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // Wishbone classic slave
  input  wire logic [msc_pkg::MSC_ADR_W-1:0] adr_i,
  input  wire logic [msc_pkg::MSC_DAT_W-1:0] dat_i,
  output var  logic [msc_pkg::MSC_DAT_W-1:0] dat_o,
  input  wire logic                          we_i,
  input  wire logic [msc_pkg::MSC_SEL_W-1:0] sel_i,
  input  wire logic                          cyc_i,
  input  wire logic                          stb_i,
  output var  logic                          ack_o,
  // MAC event strobes, one clock wide per event
  input  wire logic                          rx_frame_i,
  input  wire logic                          rx_frame_valid_i,
  input  wire logic                          tx_frame_i,
  input  wire logic                          tx_byte_i,
  input  wire logic                          tx_byte_valid_i
);
  import msc_pkg::*;

  // Elaboration checks: the decode and the flag word assume this geometry
  if (CNT_W < 1 || CNT_W > MSC_DAT_W) begin : g_bad_cnt_w
    $error("msc_stats: CNT_W must lie between 1 and the bus width");
  end
  if (MSC_ADR_W != 12) begin : g_bad_adr_w
    $error("msc_stats: the register offsets are 12-bit byte addresses");
  end
  if (MSC_NUM_CNT > MSC_DAT_W || MSC_CTRL_EN_BIT >= MSC_DAT_W) begin : g_bad_fields
    $error("msc_stats: register fields must fit in one data word");
  end
  if (MSC_SEL_W * 8 != MSC_DAT_W) begin : g_bad_sel_w
    $error("msc_stats: one byte select per data byte is expected");
  end
  // Word decode drops address bits 1:0, so every offset must be word aligned
  if (MSC_OFS_RX_FRAME[1:0]     != 2'b00 ||
      MSC_OFS_RX_GOOD[1:0]      != 2'b00 ||
      MSC_OFS_TX_FRAME[1:0]     != 2'b00 ||
      MSC_OFS_TX_BYTE[1:0]      != 2'b00 ||
      MSC_OFS_TX_GOOD_BYTE[1:0] != 2'b00 ||
      MSC_OFS_CTRL[1:0]         != 2'b00 ||
      MSC_OFS_WRAP[1:0]         != 2'b00) begin : g_bad_align
    $error("msc_stats: every register offset must be word aligned");
  end

  // ---------------------------------------------------------------
  // Event collection
  // ---------------------------------------------------------------
  logic [MSC_NUM_CNT-1:0] events;
  logic [MSC_NUM_CNT-1:0] wrap_pulse;
  logic [CNT_W-1:0]       count_val [MSC_NUM_CNT];

  assign events[MSC_IDX_RX_FRAME]     = rx_frame_i;
  assign events[MSC_IDX_RX_GOOD]      = rx_frame_valid_i;
  assign events[MSC_IDX_TX_FRAME]     = tx_frame_i;
  assign events[MSC_IDX_TX_BYTE]      = tx_byte_i;
  assign events[MSC_IDX_TX_GOOD_BYTE] = tx_byte_valid_i;

  // ---------------------------------------------------------------
  // Control: counting enable
  // ---------------------------------------------------------------
  // Pausing only stops increments; it never clears, so values stay
  // meaningful across a pause.
  logic count_en;

  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic [MSC_ADR_W-1:0] word_adr;

  assign bus_req  = cyc_i & stb_i & ~ack_o;
  assign bus_wr   = bus_req & we_i;
  assign bus_rd   = bus_req & ~we_i;
  assign word_adr = {adr_i[MSC_ADR_W-1:2], 2'b00};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_en <= MSC_EN_RESET;
    end else if (bus_wr && word_adr == MSC_OFS_CTRL && sel_i[0]) begin
      count_en <= dat_i[MSC_CTRL_EN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Counter bank
  // ---------------------------------------------------------------
  // reset-only clear
  for (genvar g = 0; g < MSC_NUM_CNT; g++) begin : g_cnt
    msc_counter #(
      .WIDTH (CNT_W)
    ) u_counter (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .inc_i   (events[g]),
      .en_i    (count_en),
      .count_o (count_val[g]),
      .wrap_o  (wrap_pulse[g])
    );
  end

  // Named views of the bank
  logic [CNT_W-1:0] rx_all_frames_value;
  logic [CNT_W-1:0] rx_valid_frames_value;
  logic [CNT_W-1:0] tx_all_frames_value;
  logic [CNT_W-1:0] tx_all_bytes_value;
  logic [CNT_W-1:0] tx_valid_bytes_value;

  assign rx_all_frames_value   = count_val[MSC_IDX_RX_FRAME];
  assign rx_valid_frames_value = count_val[MSC_IDX_RX_GOOD];
  assign tx_all_frames_value   = count_val[MSC_IDX_TX_FRAME];
  assign tx_all_bytes_value    = count_val[MSC_IDX_TX_BYTE];
  assign tx_valid_bytes_value  = count_val[MSC_IDX_TX_GOOD_BYTE];

  // ---------------------------------------------------------------
  // Sticky wrap flags, write one to clear
  // ---------------------------------------------------------------
  // These help software spot a missed rollover when the interval
  // advice was not kept; a wrap in the clearing cycle survives.
  logic [MSC_NUM_CNT-1:0] wrap_flags;
  logic [MSC_NUM_CNT-1:0] wrap_clr;

  assign wrap_clr = (bus_wr && word_adr == MSC_OFS_WRAP && sel_i[0]) ?
                    dat_i[MSC_NUM_CNT-1:0] : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wrap_flags <= MSC_WRAP_RESET;
    end else begin
      wrap_flags <= (wrap_flags & ~wrap_clr) | wrap_pulse;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Map by byte offset; counters are read-only:
  //   0x200 all received frames      0x204 valid received frames
  //   0x300 all transmitted frames   0x308 all transmitted bytes
  //   0x30C valid transmitted bytes
  //   0x3F0 bit 0 counting enable, read/write, set after reset
  //   0x3F4 bits 4:0 wrap flags, write one to clear
  //   Anything else reads zero and drops writes
  // Bus bits 7:0 carry the byte at the lowest address of each word,
  // so a byte-wide reader at offset +0 sees the least significant byte.
  logic [MSC_DAT_W-1:0] next_dat;

  function automatic logic [MSC_DAT_W-1:0] widen(input logic [CNT_W-1:0] v);
    logic [MSC_DAT_W-1:0] r;
    r = '0;
    r[CNT_W-1:0] = v;
    return r;
  endfunction : widen

  always_comb begin
    next_dat = MSC_READ_ZERO;
    case (word_adr)
      MSC_OFS_RX_FRAME:     next_dat = widen(rx_all_frames_value);
      MSC_OFS_RX_GOOD:      next_dat = widen(rx_valid_frames_value);
      MSC_OFS_TX_FRAME:     next_dat = widen(tx_all_frames_value);
      MSC_OFS_TX_BYTE:      next_dat = widen(tx_all_bytes_value);
      MSC_OFS_TX_GOOD_BYTE: next_dat = widen(tx_valid_bytes_value);
      MSC_OFS_CTRL: begin
        next_dat[MSC_CTRL_EN_BIT] = count_en;
      end
      MSC_OFS_WRAP: begin
        next_dat[MSC_NUM_CNT-1:0] = wrap_flags;
      end
      default:              next_dat = MSC_READ_ZERO;
    endcase
  end

  // Data is captured at the request edge so it matches the ack cycle;
  // an event landing that same edge shows on the next read.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= MSC_READ_ZERO;
    end else if (bus_rd) begin
      dat_o <= next_dat;
    end else if (bus_wr) begin
      dat_o <= MSC_READ_ZERO;
    end
  end

  // Every access, mapped or not, answers after one cycle; writes to
  // counters are taken and dropped since they are read-only.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req;
    end
  end

endmodule : msc_stats

`default_nettype wire

/* File: include/msc_pkg.sv */
// Package for the MAC statistics counter bank: offsets, indices, fields and reset values
package msc_pkg;

  // Bus geometry
  localparam int unsigned MSC_ADR_W  = 12;
  localparam int unsigned MSC_DAT_W  = 32;
  localparam int unsigned MSC_SEL_W  = 4;
  localparam int unsigned MSC_CNT_W  = 32;
  localparam int unsigned MSC_NUM_CNT = 5;

  // Register byte offsets (all word aligned)
  localparam logic [11:0] MSC_OFS_RX_FRAME    = 12'h200;
  localparam logic [11:0] MSC_OFS_RX_GOOD     = 12'h204;
  localparam logic [11:0] MSC_OFS_TX_FRAME    = 12'h300;
  localparam logic [11:0] MSC_OFS_TX_BYTE     = 12'h308;
  localparam logic [11:0] MSC_OFS_TX_GOOD_BYTE = 12'h30C;
  localparam logic [11:0] MSC_OFS_CTRL        = 12'h3F0;
  localparam logic [11:0] MSC_OFS_WRAP        = 12'h3F4;

  // Counter slot indices inside the bank
  localparam int unsigned MSC_IDX_RX_FRAME     = 0;
  localparam int unsigned MSC_IDX_RX_GOOD      = 1;
  localparam int unsigned MSC_IDX_TX_FRAME     = 2;
  localparam int unsigned MSC_IDX_TX_BYTE      = 3;
  localparam int unsigned MSC_IDX_TX_GOOD_BYTE = 4;

  // Control register fields
  localparam int unsigned MSC_CTRL_EN_BIT = 0;

  // Reset values
  localparam logic [31:0] MSC_CNT_RESET  = 32'h0000_0000;
  localparam logic        MSC_EN_RESET   = 1'h1;
  localparam logic [4:0]  MSC_WRAP_RESET = 5'h00;
  localparam logic [31:0] MSC_READ_ZERO  = 32'h0000_0000;

endpackage : msc_pkg

/* File: logic/msc_counter.sv */
// One wrapping statistics counter with a registered wrap pulse
`timescale 1ns/1ps
`default_nettype none

module msc_counter #(
  parameter int unsigned WIDTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             inc_i,
  input  wire logic             en_i,
  output var  logic [WIDTH-1:0] count_o,
  output var  logic             wrap_o
);
  import msc_pkg::*;

  if (WIDTH < 1 || WIDTH > MSC_DAT_W) begin : g_bad_width
    $error("msc_counter: WIDTH must lie between 1 and the bus width");
  end

  logic step;
  assign step = inc_i & en_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= MSC_CNT_RESET[WIDTH-1:0];
    end else if (step) begin
      count_o <= count_o + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // Pulse in the cycle after the all-ones value rolls over to zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wrap_o <= 1'b0;
    end else begin
      wrap_o <= step & (&count_o);
    end
  end

endmodule : msc_counter

`default_nettype wire

/* File: dv/msc_stats_sva.sv */
// Bus timing and reset value checker for the statistics counter bank
`timescale 1ns/1ps
`default_nettype none
module msc_stats_chk #(
  parameter int unsigned CNT_W = 32
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [11:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        we_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic        rx_frame_i,
  input wire logic        rx_frame_valid_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_rx_read;
    s_take ##0 !we_i && adr_i[11:8] == 4'h2;
  endsequence
  chk_ack_next:
    assert property (s_take |=> ack_o) else $error("ack missing");
  chk_ack_pulse:
    assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  chk_ack_cause:
    assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
  chk_data_hold:
    assert property (!rst_i && !(cyc_i && stb_i) |=> $stable(dat_o))
      else $error("read data moved");
  chk_write_zero:
    assert property (s_take ##0 we_i |=> dat_o == 32'h0) else $error("data after write");
  chk_hole_zero:
    assert property (s_take ##0 !we_i && adr_i[11:8] == 4'h1 |=> dat_o == 32'h0)
      else $error("unmapped read not zero");
  chk_reset_zero:
    assert property ($past(rst_i) |-> !ack_o && dat_o == 32'h0) else $error("reset values");
  chk_fresh_read:
    assert property ($past(rst_i, 2) && !$past(rx_frame_i || rx_frame_valid_i) ##0 s_rx_read
      |=> dat_o == 32'h0) else $error("counter not zero after reset");
endmodule : msc_stats_chk
bind msc_stats msc_stats_chk #(.CNT_W(CNT_W)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .adr_i(adr_i), .dat_o(dat_o), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .rx_frame_i(rx_frame_i), .rx_frame_valid_i(rx_frame_valid_i));
`default_nettype wire

/* File: dv/msc_stats_test.sv */
// Self-checking bench for the statistics counter bank
`timescale 1ns/1ps
`default_nettype none
module msc_stats_test;
  import msc_pkg::*;
  // Narrow counters so that wrapping is reached in a short run
  localparam int CW = 4;
  logic        clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0, ack_o;
  logic [11:0] adr_i = '0;
  logic [31:0] dat_i = '0, dat_o, rd;
  logic [3:0]  sel_i = '0;
  logic [4:0]  ev = '0, r, wrapm = '0;
  logic        en = 1'b1;
  logic [31:0] start, wd;
  int          k;
  int          miscompares = 0, compares = 0, cycles = 0;
  int unsigned model [5];
  logic [11:0] ofs [5] = '{MSC_OFS_RX_FRAME, MSC_OFS_RX_GOOD, MSC_OFS_TX_FRAME,
                           MSC_OFS_TX_BYTE, MSC_OFS_TX_GOOD_BYTE};
  always #4 clk_i = ~clk_i;
  msc_stats #(.CNT_W(CW)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
    .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .rx_frame_i(ev[0]), .rx_frame_valid_i(ev[1]),
    .tx_frame_i(ev[2]), .tx_byte_i(ev[3]), .tx_byte_valid_i(ev[4]));
  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      $display("Error at %0t: cycle limit reached", $time);
      miscompares++;
      close_out();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: read %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wb(input logic [11:0] a, input logic w, input logic [31:0] d,
                    input logic [3:0] s);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    adr_i <= a;
    we_i <= w;
    dat_i <= d;
    sel_i <= s;
    // Hold the request until ack is seen; only the cycle ceiling ends a hang
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic read_all();
    for (int i = 0; i < 5; i++) begin
      wb(ofs[i], 1'b0, 32'h0, 4'($urandom));
      check(rd, 32'(model[i] % (1 << CW)));
    end
  endtask : read_all
  // Drive n cycles of events on the inputs in m, random or all of them
  task automatic pulse(input int n, input logic [4:0] m, input logic fixed);
    for (int c = 0; c < n; c++) begin
      r = fixed ? m : (5'($urandom) & m);
      ev <= r;
      for (int b = 0; b < 5; b++) begin
        if (r[b] && en) begin
          model[b]++;
          if (model[b] % (1 << CW) == 0) wrapm[b] = 1'b1;
        end
      end
      @(posedge clk_i);
    end
    ev <= '0;
    @(posedge clk_i);
  endtask : pulse
  task automatic check_wrap();
    wb(MSC_OFS_WRAP, 1'b0, 32'h0, 4'($urandom));
    check(rd, {27'h0, wrapm});
  endtask : check_wrap
  initial begin
    void'($urandom(32'hB398F626));
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    read_all();
    check_wrap();
    wb(MSC_OFS_CTRL, 1'b0, 32'h0, 4'($urandom));
    check(rd, 32'h1);
    repeat (2) begin
      pulse(150, 5'h1F, 1'b0);
      read_all();
      // Counters are read-only, so these writes must leave them alone
      wb(ofs[$urandom % 5], 1'b1, $urandom, 4'($urandom));
      wb(12'h100, 1'b1, $urandom, 4'($urandom));
      wb(12'h104, 1'b0, 32'h0, 4'($urandom));
      check(rd, 32'h0);
      check_wrap();
      // Without byte select 0 the clear is dropped
      wb(MSC_OFS_WRAP, 1'b1, 32'h1F, 4'hE);
      check_wrap();
      wd = $urandom;
      wb(MSC_OFS_WRAP, 1'b1, wd, 4'h1);
      wrapm = wrapm & ~wd[4:0];
      check_wrap();
    end
    wb(MSC_OFS_TX_BYTE, 1'b0, 32'h0, 4'($urandom));
    start = rd;
    k = 1 + $urandom % 14;
    pulse(k, 5'h08, 1'b1);
    wb(MSC_OFS_TX_BYTE, 1'b0, 32'h0, 4'($urandom));
    check((rd - start) & 32'((1 << CW) - 1), 32'(k));
    // Paused counting drops events and keeps the values
    wb(MSC_OFS_CTRL, 1'b1, 32'h0, 4'h1);
    en = 1'b0;
    wb(MSC_OFS_CTRL, 1'b0, 32'h0, 4'($urandom));
    check(rd, 32'h0);
    pulse(20, 5'h1F, 1'b0);
    read_all();
    wb(MSC_OFS_CTRL, 1'b1, 32'h1, 4'h1);
    en = 1'b1;
    pulse(20, 5'h1F, 1'b0);
    read_all();
    // Leave counting paused so that reset must bring the enable back
    wb(MSC_OFS_CTRL, 1'b1, 32'h0, 4'h1);
    rst_i <= 1;
    @(posedge clk_i);
    rst_i <= 0;
    model = '{default: 0};
    wrapm = '0;
    en = 1'b1;
    @(posedge clk_i);
    read_all();
    check_wrap();
    wb(MSC_OFS_CTRL, 1'b0, 32'h0, 4'($urandom));
    check(rd, 32'h1);
    close_out();
  end
endmodule : msc_stats_test
`default_nettype wire
